/* File: core/battmon_bank.sv */
// battery monitor memory pages, status flags and measurement registers
`timescale 1ns/10ps
`include "battmon_defs.svh"
// **********************************************************************
// Functional notes
// R1 - memory spans five pages of 32 bytes, only some bytes implemented
// R2 - pages one to three write a readable scratchpad, copy moves it to backing
// R3 - register page is volatile except the page-one lock bit; here reset clears the lock bit too
// R4 - page five holds fixed manufacturer id and nonvolatile cycle counter; here reset clears the counter
// R5 - page one has 24 bytes, scratch and backing laid out alike
// R6 - page one can be locked against changes to its backing bytes
// R7 - page two has 8 bytes with backing, no lock
// R8 - page three has 8 bytes backed by volatile storage
// R9 - temperature is 13-bit two's complement, left aligned, 60h-61h
// R10 - temperature high byte holds sign and integer, low byte fraction
// R11 - status is read-only at 62h low byte and 63h high byte
// R12 - status low byte: busy, copy busy, lock, adc busy; 63h reads ones
// R13 - temperature busy is set during conversion, clear when data valid
// R14 - copy busy is set while copying, copy lasts 2 to 10 ms
// R15 - lock flag shows protection and is kept through supply loss; here reset clears it
// R16 - adc busy set during a conversion of about 10 ms
// R17 - command b4h starts 10-bit voltage conversion into 77h-78h
// R18 - voltage is unsigned binary with 10 mV per count
// R19 - all accesses come over the bus port, writes via scratchpad
// R20 - cycle counter saturates at ffffh
// R21 - writes to read-only registers are ignored
// **********************************************************************
module battmon_bank #(
    parameter int ADC_CYCLES = `ADC_CYCLES,
    parameter int COPY_CYCLES = `COPY_CYCLES,
    // arbitrary neutral value
    parameter logic [15:0] MFG_ID = `MFG_ID_DEFAULT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] mem_addr,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_rd,
    input wire logic mem_scratch,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire battmon_pkg::page_e cmd_page,
    output logic cmd_accept,
    output logic temp_start,
    input wire logic temp_ready,
    input wire logic [12:0] temp_value,
    output logic adc_start,
    input wire logic [9:0] adc_value,
    output logic temp_conversion_busy,
    output logic nv_copy_busy,
    output logic adc_conversion_busy,
    output logic page_one_locked
);
    import battmon_pkg::*;
    // **********************************************************************
    // address decode
    // **********************************************************************
    page_e addr_page;
    logic [4:0] addr_off;
    logic sp_ok;
    logic [5:0] sp_idx;
    assign addr_page = page_e'(mem_addr[7:5]);
    assign addr_off = mem_addr[4:0];
    // R1 page map
    always_comb begin
        sp_ok = 1'b0;
        sp_idx = 6'h00;
        case (addr_page)
            PG_ONE: begin
                sp_ok = addr_off < `P1_BYTES;
                sp_idx = {1'b0, addr_off};
            end
            PG_TWO: begin
                sp_ok = addr_off < `P2_BYTES;
                sp_idx = `P2_BASE + {3'b000, addr_off[2:0]};
            end
            PG_THREE: begin
                sp_ok = addr_off < `P3_BYTES;
                sp_idx = `P3_BASE + {3'b000, addr_off[2:0]};
            end
            default: sp_idx = 6'h00;
        endcase
    end
    // **********************************************************************
    // command decode
    // **********************************************************************
    logic lock_reg, copy_busy, adc_busy, adc_done, temp_busy_reg;
    logic is_conv_v, is_conv_t, is_copy, is_lock, is_unlock, is_inc, is_rst;
    logic conv_v_go, conv_t_go, copy_go, nv_go, lock_go, unlock_go;
    assign is_conv_v = cmd_valid && (cmd_code == `CMD_CONVERT_V);
    assign is_conv_t = cmd_valid && (cmd_code == `CMD_CONVERT_T);
    assign is_copy = cmd_valid && (cmd_code == `CMD_COPY_SP);
    assign is_lock = cmd_valid && (cmd_code == `CMD_LOCK);
    assign is_unlock = cmd_valid && (cmd_code == `CMD_UNLOCK);
    assign is_inc = cmd_valid && (cmd_code == `CMD_CYC_INC);
    assign is_rst = cmd_valid && (cmd_code == `CMD_CYC_RST);
    // R17 convert voltage command
    assign conv_v_go = is_conv_v && !adc_busy;
    assign conv_t_go = is_conv_t && !temp_busy_reg;
    // R6 locked page one refuses the copy
    assign nv_go = is_copy && !copy_busy &&
        ((cmd_page == PG_ONE && !lock_reg) || cmd_page == PG_TWO);
    // R8 sram page copies at once, no eeprom wait
    assign copy_go = nv_go || (is_copy && cmd_page == PG_THREE);
    // lock state lives in eeprom, so lock and unlock are refused while a copy runs
    assign lock_go = is_lock && !copy_busy;
    assign unlock_go = is_unlock && !copy_busy;
    // one-cycle acknowledge of every command actually taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_accept <= 1'b0;
        end else begin
            cmd_accept <= conv_v_go || conv_t_go || copy_go || lock_go ||
                unlock_go || is_inc || is_rst;
        end
    end
    // **********************************************************************
    // scratchpad and backing cells
    // **********************************************************************
    logic [7:0] scratch_word [0:`SP_TOTAL-1];
    logic [7:0] backing_word [0:`SP_TOTAL-1];
    genvar gi;
    generate
        for (gi = 0; gi < `SP_TOTAL; gi++) begin : g_cell
            localparam page_e CELL_PAGE = (gi < 24) ? PG_ONE :
                (gi < 32) ? PG_TWO : PG_THREE;
            logic [7:0] sp_reg;
            logic [7:0] bk_reg;
            // R19 bus writes land only in the scratchpad
            always_ff @(posedge clk) begin
                if (mem_wr && sp_ok && sp_idx == 6'(gi)) begin
                    sp_reg <= mem_wdata;
                end
            end
            // R2 copy snapshots the scratch page at command time
            // R5 page one cells map byte for byte
            // R7 page two backing is never locked
            always_ff @(posedge clk) begin
                if (copy_go && cmd_page == CELL_PAGE) begin
                    bk_reg <= sp_reg;
                end
            end
            assign scratch_word[gi] = sp_reg;
            assign backing_word[gi] = bk_reg;
        end
    endgenerate
    // **********************************************************************
    // nonvolatile copy timing and lock
    // **********************************************************************
    // R14 eeprom copy busy window
    busy_timer #(
        .WIDTH(`TIMER_W),
        .COUNT(COPY_CYCLES)
    ) u_copy_timer (
        .clk(clk),
        .resetn(resetn),
        .start(nv_go),
        .busy(copy_busy),
        .done()
    );
    // R3 lock kept in its own register, cleared by reset like the volatile ones
    // R15 lock flag set by command only, cleared by command or by reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_reg <= `LOCK_RESET;
        end else if (lock_go) begin
            lock_reg <= 1'b1;
        end else if (unlock_go) begin
            lock_reg <= 1'b0;
        end
    end
    // **********************************************************************
    // temperature conversion
    // **********************************************************************
    logic rdy_s1_reg, rdy_s2_reg, rdy_s3_reg, rdy_lvl_reg, temp_done;
    logic [15:0] temp_reg, volt_reg, cyc_reg;
    // three-stage catch of the sensor ready pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
            rdy_s3_reg <= 1'b0;
            rdy_lvl_reg <= 1'b0;
        end else begin
            rdy_s1_reg <= temp_ready;
            rdy_s2_reg <= rdy_s1_reg;
            rdy_s3_reg <= rdy_s2_reg;
            if (rdy_s2_reg == rdy_s3_reg) begin
                rdy_lvl_reg <= rdy_s3_reg;
            end
        end
    end
    assign temp_done = temp_busy_reg && !rdy_lvl_reg && rdy_s2_reg && rdy_s3_reg;
    // R13 busy from start until the result is stored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_busy_reg <= 1'b0;
            temp_start <= 1'b0;
        end else begin
            temp_start <= conv_t_go;
            if (conv_t_go) begin
                temp_busy_reg <= 1'b1;
            end else if (temp_done) begin
                temp_busy_reg <= 1'b0;
            end
        end
    end
    // R9 left aligned, low three bits zero
    // R10 sign and integer land in the high byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_reg <= 16'h0000;
        end else if (temp_done) begin
            temp_reg <= {temp_value, 3'b000};
        end
    end
    // **********************************************************************
    // battery voltage conversion
    // **********************************************************************
    // R16 adc busy for the conversion time
    busy_timer #(
        .WIDTH(`TIMER_W),
        .COUNT(ADC_CYCLES)
    ) u_adc_timer (
        .clk(clk),
        .resetn(resetn),
        .start(conv_v_go),
        .busy(adc_busy),
        .done(adc_done)
    );
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            adc_start <= 1'b0;
        end else begin
            adc_start <= conv_v_go;
        end
    end
    // R18 unsigned 10 mV counts, converter holds value until done
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            volt_reg <= 16'h0000;
        end else if (adc_done) begin
            volt_reg <= {6'b000000, adc_value};
        end
    end
    // **********************************************************************
    // cycle counter
    // **********************************************************************
    // R4 counter beside the fixed id
    // R20 no wrap past ffffh
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_reg <= `CYC_RESET;
        end else if (is_rst) begin
            cyc_reg <= `CYC_RESET;
        end else if (is_inc && cyc_reg != `CYC_MAX) begin
            cyc_reg <= cyc_reg + 16'h0001;
        end
    end
    // **********************************************************************
    // read path
    // **********************************************************************
    logic [7:0] status_lo, rd_byte;
    // R12 defined flags only in the low status byte
    always_comb begin
        status_lo = 8'h00;
        status_lo[`ST_TB] = temp_busy_reg;
        status_lo[`ST_NVB] = copy_busy;
        status_lo[`ST_LOCK] = lock_reg;
        status_lo[`ST_ADB] = adc_busy;
    end
    // R11 status reads, no write path exists
    // R21 only scratch cells take writes
    always_comb begin
        rd_byte = `RESERVED_RD;
        if (sp_ok) begin
            rd_byte = mem_scratch ? scratch_word[sp_idx] : backing_word[sp_idx];
        end else begin
            case (mem_addr)
                `ADDR_TEMP_LSB: rd_byte = temp_reg[7:0];
                `ADDR_TEMP_MSB: rd_byte = temp_reg[15:8];
                `ADDR_STAT_LSB: rd_byte = status_lo;
                `ADDR_STAT_MSB: rd_byte = `STAT_MSB_VAL;
                `ADDR_VOLT_LSB: rd_byte = volt_reg[7:0];
                `ADDR_VOLT_MSB: rd_byte = volt_reg[15:8];
                `ADDR_MFG_LSB: rd_byte = MFG_ID[7:0];
                `ADDR_MFG_MSB: rd_byte = MFG_ID[15:8];
                `ADDR_CYC_LSB: rd_byte = cyc_reg[7:0];
                `ADDR_CYC_MSB: rd_byte = cyc_reg[15:8];
                default: rd_byte = `RESERVED_RD;
            endcase
        end
    end
    // read answers one cycle later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_rdata <= 8'h00;
            mem_rvalid <= 1'b0;
        end else begin
            mem_rvalid <= mem_rd;
            if (mem_rd) begin
                mem_rdata <= rd_byte;
            end
        end
    end
    assign temp_conversion_busy = temp_busy_reg;
    assign nv_copy_busy = copy_busy;
    assign adc_conversion_busy = adc_busy;
    assign page_one_locked = lock_reg;
    // **********************************************************************
    // assertions
    // **********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    int copy_len_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            copy_len_reg <= 0;
        end else if (copy_busy) begin
            copy_len_reg <= copy_len_reg + 1;
        end else begin
            copy_len_reg <= 0;
        end
    end
    sequence s_nv_copy;
        is_copy && !copy_busy && (cmd_page == PG_ONE && !lock_reg || cmd_page == PG_TWO);
    endsequence
    sequence s_locked_copy;
        is_copy && !copy_busy && cmd_page == PG_ONE && lock_reg;
    endsequence
    sequence s_rd_stat_hi;
        mem_rd && mem_addr == `ADDR_STAT_MSB;
    endsequence
    sequence s_rd_stat_lo;
        mem_rd && mem_addr == `ADDR_STAT_LSB;
    endsequence
    a_stat_hi_ones: assert property (s_rd_stat_hi |=> mem_rvalid && mem_rdata == 8'hff) // R12
        else $error("status high byte not all ones");
    a_stat_lo_flags: assert property (s_rd_stat_lo |=> mem_rdata == {4'h0,
        $past(adc_busy), $past(lock_reg), $past(copy_busy), $past(temp_busy_reg)}) // R11
        else $error("status low byte wrong");
    a_copy_busy_on: assert property (s_nv_copy |=> nv_copy_busy [*2]) // R14
        else $error("copy busy not raised");
    a_copy_busy_len: assert property ($fell(copy_busy) |-> copy_len_reg == COPY_CYCLES) // R14
        else $error("copy busy length wrong");
    a_lock_blocks: assert property (s_locked_copy |=> !nv_copy_busy && !cmd_accept) // R6
        else $error("locked page one copy started");
    a_adc_start: assert property (conv_v_go |=> adc_conversion_busy && adc_start) // R17
        else $error("voltage conversion not started");
    a_volt_load: assert property ($fell(adc_busy) |=> volt_reg[9:0] == $past(adc_value)) // R18
        else $error("voltage result not stored");
    a_cyc_sat: assert property (is_inc && cyc_reg == 16'hffff |=> cyc_reg == 16'hffff) // R20
        else $error("cycle counter wrapped");
    a_ro_write: assert property (mem_wr && !adc_done && !temp_done
        |=> $stable(volt_reg) && $stable(temp_reg)) // R21
        else $error("write altered a read-only register");
    a_wr_scratch: assert property (mem_wr && sp_ok
        |=> scratch_word[$past(sp_idx)] == $past(mem_wdata)) // R2
        else $error("scratch write lost");
    a_temp_busy: assert property (conv_t_go |=> temp_conversion_busy && temp_start) // R13
        else $error("temperature busy not raised");
    a_temp_align: assert property (mem_rd && mem_addr == `ADDR_TEMP_LSB
        |=> mem_rdata[2:0] == 3'b000) // R9
        else $error("temperature low bits not zero");
endmodule : battmon_bank

/* File: core/battmon_defs.svh */
// constants for the battery monitor memory and measurement bank
`ifndef BATTMON_DEFS_SVH
`define BATTMON_DEFS_SVH
// page geometry
`define PAGE_BYTES 32
`define P1_BYTES 5'd24
`define P2_BYTES 5'd8
`define P3_BYTES 5'd8
`define SP_TOTAL 40
`define P2_BASE 6'd24
`define P3_BASE 6'd32
// register page and id page byte addresses
`define ADDR_TEMP_LSB 8'h60
`define ADDR_TEMP_MSB 8'h61
`define ADDR_STAT_LSB 8'h62
`define ADDR_STAT_MSB 8'h63
`define ADDR_VOLT_LSB 8'h77
`define ADDR_VOLT_MSB 8'h78
`define ADDR_MFG_LSB 8'h80
`define ADDR_MFG_MSB 8'h81
`define ADDR_CYC_LSB 8'h82
`define ADDR_CYC_MSB 8'h83
// status byte fields and fixed read values
`define ST_TB 0
`define ST_NVB 1
`define ST_LOCK 2
`define ST_ADB 3
`define STAT_MSB_VAL 8'hff
`define RESERVED_RD 8'h00
// command codes
`define CMD_CONVERT_V 8'hb4
`define CMD_CONVERT_T 8'hd2
`define CMD_COPY_SP 8'h51
`define CMD_LOCK 8'h43
`define CMD_UNLOCK 8'h44
`define CMD_CYC_INC 8'hb5
`define CMD_CYC_RST 8'hb8
// widths and reset values
`define TEMP_BITS 13
`define VOLT_BITS 10
`define TIMER_W 20
`define LOCK_RESET 1'b0
`define CYC_RESET 16'h0000
`define CYC_MAX 16'hffff
`define MFG_ID_DEFAULT 16'h5a5a
// timing
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define ADC_TIME_MS 10
`define COPY_MIN_MS 2
`define COPY_MAX_MS 10
`define ADC_CYCLES ((`ADC_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define COPY_CYCLES ((`COPY_MIN_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: core/battmon_pkg.sv */
// types shared by the battery monitor bank
package battmon_pkg;
    // the five pages in address order
    typedef enum logic [2:0] {
        PG_ONE,
        PG_TWO,
        PG_THREE,
        PG_REGS,
        PG_MFG
    } page_e;
    typedef logic [7:0] byte_t;
endpackage : battmon_pkg

/* File: core/busy_timer.sv */
// one-shot busy timer: busy for COUNT cycles after start, then a done pulse
`timescale 1ns/10ps
`include "battmon_defs.svh"
module busy_timer #(
    parameter int WIDTH = `TIMER_W,
    parameter int COUNT = 1000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] cnt_reg;
    logic busy_reg;
    logic done_reg;

    // start is ignored while already running
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!busy_reg && start) begin
                busy_reg <= 1'b1;
                cnt_reg <= WIDTH'(COUNT - 1);
            end else if (busy_reg) begin
                if (cnt_reg == '0) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule : busy_timer

/* File: test/battmon_bank_tb.sv */
// self-checking bench for the battery monitor bank
`timescale 1ns/10ps
module battmon_bank_tb;
    import battmon_pkg::*;
    localparam int ADC_N = 20;
    localparam int COPY_N = 10;
    // arbitrary maker code
    localparam logic [15:0] MFG = 16'h3c96;
    logic clk = 0;
    logic resetn = 0;
    logic [7:0] mem_addr = 0;
    logic mem_wr = 0;
    logic [7:0] mem_wdata = 0;
    logic mem_rd = 0;
    logic mem_scratch = 0;
    logic [7:0] mem_rdata;
    logic mem_rvalid;
    logic cmd_valid = 0;
    logic [7:0] cmd_code = 0;
    page_e cmd_page = PG_ONE;
    logic cmd_accept, temp_start, temp_ready, adc_start;
    logic [12:0] temp_value, temp_set = 0;
    logic [9:0] adc_value, adc_set = 0;
    logic temp_conversion_busy, nv_copy_busy, adc_conversion_busy, page_one_locked;
    logic [7:0] exp_q[$];
    string name_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [31:0] rng = 32'h19bb;
    logic [7:0] d0, d1;

    always #5 clk = ~clk;

    battmon_bank #(.ADC_CYCLES(ADC_N), .COPY_CYCLES(COPY_N), .MFG_ID(MFG)) i_dut (
        .clk, .resetn, .mem_addr, .mem_wr, .mem_wdata, .mem_rd, .mem_scratch,
        .mem_rdata, .mem_rvalid, .cmd_valid, .cmd_code, .cmd_page, .cmd_accept,
        .temp_start, .temp_ready, .temp_value, .adc_start, .adc_value,
        .temp_conversion_busy, .nv_copy_busy, .adc_conversion_busy, .page_one_locked
    );

    sensor_model i_sens (
        .clk, .resetn, .temp_start, .adc_start, .temp_set, .adc_set,
        .temp_ready, .temp_value, .adc_value
    );

    // ************************************
    // helpers
    // ************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic s, input logic [7:0] e, input string nm);
        @(negedge clk);
        mem_rd = 1;
        mem_addr = a;
        mem_scratch = s;
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(negedge clk);
        mem_rd = 0;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        mem_wr = 1;
        mem_addr = a;
        mem_wdata = d;
        @(negedge clk);
        mem_wr = 0;
    endtask : wr

    task automatic cmd(input logic [7:0] c, input page_e p, input logic e);
        @(negedge clk);
        cmd_valid = 1;
        cmd_code = c;
        cmd_page = p;
        @(negedge clk);
        cmd_valid = 0;
        chk("cmd_accept", {15'h0, e}, {15'h0, cmd_accept});
    endtask : cmd

    // counts the cycles a busy flag still stands, bounded
    task automatic busy_len(input int k, output int len);
        len = 0;
        while (len < 1000 && (k == 0 ? temp_conversion_busy : k == 1 ? nv_copy_busy
                : adc_conversion_busy) === 1'b1) begin
            len++;
            @(negedge clk);
        end
    endtask : busy_len

    task automatic close_out;
        if (exp_q.size() != 0) begin
            mismatches++;
        end
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // read results are matched oldest first, mid-cycle where they have settled
    always @(negedge clk) begin
        if (mem_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                // a read answer nobody asked for always counts as a mismatch
                chk("spare read", 16'h0, {15'h0, mem_rvalid});
            end else begin
                chk(name_q.pop_front(), {8'h0, exp_q.pop_front()}, {8'h0, mem_rdata});
            end
        end
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    // ************************************
    // scenarios
    // ************************************
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        resetn = 1;
        rng = xs(rng);
        d0 = rng[7:0];
        d1 = rng[15:8];
        adc_set = rng[25:16];
        rd(8'h62, 0, 8'h00, "status lo");
        rd(8'h63, 0, 8'hff, "status hi");
        rd(8'h80, 0, MFG[7:0], "mfg lo");
        rd(8'h81, 0, MFG[15:8], "mfg hi");
        rd(8'h64, 0, 8'h00, "reserved p4");
        rd(8'h18, 1, 8'h00, "reserved p1");
        // page two staging and timed copy
        wr(8'h27, d0);
        rd(8'h27, 1, d0, "p2 scratch");
        cmd(8'h51, PG_TWO, 1);
        cmd(8'h51, PG_TWO, 0);
        busy_len(1, n);
        // counting starts at the third cycle of the copy window
        chk("copy busy len", 16'(COPY_N - 2), n[15:0]);
        rd(8'h27, 0, d0, "p2 backing");
        // page one lock
        wr(8'h17, d0);
        cmd(8'h51, PG_ONE, 1);
        busy_len(1, n);
        cmd(8'h43, PG_ONE, 1);
        rd(8'h62, 0, 8'h04, "status lock");
        wr(8'h17, d1);
        cmd(8'h51, PG_ONE, 0);
        rd(8'h17, 0, d0, "p1 backing");
        rd(8'h17, 1, d1, "p1 scratch");
        cmd(8'h44, PG_ONE, 1);
        // page three copies with no busy time
        wr(8'h40, d1);
        cmd(8'h51, PG_THREE, 1);
        chk("p3 busy", 16'h0, {15'h0, nv_copy_busy});
        rd(8'h40, 0, d1, "p3 backing");
        // voltage conversion, second start refused
        cmd(8'hb4, PG_ONE, 1);
        cmd(8'hb4, PG_ONE, 0);
        rd(8'h62, 0, 8'h08, "status adc");
        busy_len(2, n);
        // counting starts at the fifth cycle of the conversion
        chk("adc busy len", 16'(ADC_N - 4), n[15:0]);
        repeat (2) @(negedge clk);
        rd(8'h77, 0, adc_set[7:0], "volt lo");
        rd(8'h78, 0, {6'h0, adc_set[9:8]}, "volt hi");
        // read-only registers ignore writes
        wr(8'h62, 8'hff);
        wr(8'h77, ~adc_set[7:0]);
        rd(8'h62, 0, 8'h00, "status wr");
        rd(8'h77, 0, adc_set[7:0], "volt wr");
        // temperature conversion
        rng = xs(rng);
        temp_set = rng[12:0];
        cmd(8'hd2, PG_ONE, 1);
        rd(8'h62, 0, 8'h01, "status temp");
        busy_len(0, n);
        rd(8'h60, 0, {temp_set[4:0], 3'b000}, "temp lo");
        rd(8'h61, 0, temp_set[12:5], "temp hi");
        rd(8'h62, 0, 8'h00, "status done");
        // cycle counter and an unknown code
        cmd(8'hb8, PG_ONE, 1);
        cmd(8'hb5, PG_ONE, 1);
        cmd(8'hb5, PG_ONE, 1);
        cmd(8'h00, PG_ONE, 0);
        rd(8'h82, 0, 8'h02, "count lo");
        rd(8'h83, 0, 8'h00, "count hi");
        repeat (3) @(negedge clk);
        close_out();
    end
endmodule : battmon_bank_tb

/* File: test/sensor_model.sv */
// behavioural temperature sensor and voltage converter facing the bank
`timescale 1ns/10ps
module sensor_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic temp_start,
    input wire logic adc_start,
    input wire logic [12:0] temp_set,
    input wire logic [9:0] adc_set,
    output logic temp_ready,
    output logic [12:0] temp_value,
    output logic [9:0] adc_value
);
    int tcnt;
    int acnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tcnt <= 0;
            acnt <= 0;
        end else begin
            tcnt <= temp_start ? 20 : (tcnt > 0 ? tcnt - 1 : 0);
            acnt <= adc_start ? 30 : (acnt > 0 ? acnt - 1 : 0);
        end
    end
    // data is only good inside the window, inverted outside it
    assign temp_ready = (tcnt > 0) && (tcnt < 13);
    assign temp_value = temp_ready ? temp_set : ~temp_set;
    assign adc_value = (acnt > 0) ? adc_set : ~adc_set;
endmodule : sensor_model
